// >>> core/ofl_limit_calc.sv
// combinational jump-band substitution and min/max clamp
`timescale 1ns/10ps
`default_nettype none
module ofl_limit_calc
  import ofl_pkg::*;
(
  input  wire ofl_pkg::ofl_freq_t cmd_i,
  input  wire logic               run_i,
  input  wire logic               jog_i,
  input  wire ofl_pkg::ofl_freq_t jog_freq_i,
  input  wire ofl_pkg::ofl_freq_t min_i,
  input  wire ofl_pkg::ofl_freq_t max_i,
  input  wire ofl_pkg::ofl_freq_t jump_i [ofl_pkg::JUMP_N],
  output ofl_pkg::ofl_freq_t      target_o
);
  import ofl_pkg::*;

  ofl_freq_t jumped;
  logic      hit;

  always_comb
  begin
    jumped = cmd_i;
    hit    = 1'b0;
    // lowest band wins; hold point is always the a bound
    for (int i = 0; i < BAND_N; i++)
    begin
      if (!hit && band_hit(cmd_i, jump_i[2*i], jump_i[2*i+1]))
      begin
        jumped = jump_i[2*i];
        hit    = 1'b1;
      end
    end
  end

  // jump first, then clamps
  always_comb
  begin
    target_o = FREQ_ZERO;
    if (jog_i)
    begin
      target_o = jog_freq_i;
      if (target_o > max_i)
        target_o = max_i;
    end
    else if (run_i)
    begin
      target_o = jumped;
      if (target_o < min_i)
        target_o = min_i;
      if (target_o > max_i)
        target_o = max_i;
    end
  end

endmodule : ofl_limit_calc
`default_nettype wire

// >>> core/ofl_limiter.sv
// output frequency limiter: apb settings, limit stage and ramp
// Function
// - maximum limit settable 0 to 120 Hz, reset 120
// - command above maximum outputs the maximum
// - minimum limit settable 0 to 120 Hz, reset 0
// - running target never below the minimum unless the minimum exceeds the maximum
// - high-speed maximum 120 to 400 Hz, reset 120
// - maximum and high-speed maximum writes copy each other
// - jog at or below minimum bypasses minimum
// - start alone ramps up to the minimum
// - three jump bands, 9999 disables a band
// - command inside band runs at a bound
// - a bound ordering picks hold edge
// - ramps pass straight through jump bands
// - max, min, high-speed max and jump settings writable only while view select zero
`timescale 1ns/10ps
`default_nettype none
module ofl_limiter
  import ofl_pkg::*;
#(
  parameter int RAMP_TICK_CYCLES = ofl_pkg::RAMP_TICK_CYC
)
(
  input  wire logic                       SYS_CLK_I,
  input  wire logic                       RESET_N_I,
  input  wire logic                       PSEL_I,
  input  wire logic                       PENABLE_I,
  input  wire logic                       PWRITE_I,
  input  wire logic [ofl_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [ofl_pkg::DATA_W-1:0] PWDATA_I,
  output logic      [ofl_pkg::DATA_W-1:0] PRDATA_O,
  output logic                            PREADY_O,
  output logic                            PSLVERR_O,
  input  wire ofl_pkg::ofl_freq_t         CMD_FREQ_I,
  input  wire logic                       START_I,
  input  wire logic                       JOG_I,
  output ofl_pkg::ofl_freq_t              OUT_FREQ_O,
  output logic                            OUT_RUNNING_O,
  output logic                            OUT_AT_SPEED_O
);
  import ofl_pkg::*;

  ofl_freq_t        max_reg;
  ofl_freq_t        min_reg;
  ofl_freq_t        hsmax_reg;
  ofl_freq_t        start_reg;
  ofl_freq_t        jog_reg;
  ofl_freq_t        accel_reg;
  ofl_freq_t        view_reg;
  ofl_freq_t        jump_reg [JUMP_N];
  ofl_freq_t        target_next;
  ofl_freq_t        target_reg;
  ofl_freq_t        run_reg;
  ofl_freq_t        run_next;
  ofl_ramp_t        ramp_state_reg;
  ofl_ramp_t        ramp_state_next;
  logic             start_meta_reg;
  logic             start_sync_reg;
  logic             jog_meta_reg;
  logic             jog_sync_reg;
  logic             tick_reg;
  logic [31:0]      tick_cnt_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic             running_reg;
  logic             at_speed_reg;
  logic [DATA_W-1:0] rd_data;
  logic             mapped;
  logic             wr_ok;
  logic             access_start;
  logic             wr_accept;
  logic [7:0]       jump_off;
  logic [2:0]       jump_idx;
  logic             is_jump;
  ofl_freq_t        wval;

  assign wval     = PWDATA_I[FREQ_W-1:0];
  assign jump_off = PADDR_I - OFF_JUMP_BASE;
  assign jump_idx = jump_off[4:2];
  assign is_jump  = (PADDR_I >= OFF_JUMP_BASE) && (PADDR_I <= OFF_JUMP_LAST) && (PADDR_I[1:0] == 2'b00);

  // two-flop synchronisers for the start and jog pins
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      start_meta_reg <= 1'b0;
      start_sync_reg <= 1'b0;
      jog_meta_reg   <= 1'b0;
      jog_sync_reg   <= 1'b0;
    end
    else
    begin
      start_meta_reg <= START_I;
      start_sync_reg <= start_meta_reg;
      jog_meta_reg   <= JOG_I;
      jog_sync_reg   <= jog_meta_reg;
    end
  end

  // apb: one wait state, answer registered
  assign access_start = PSEL_I && PENABLE_I && !pready_reg;
  assign wr_accept    = PSEL_I && PENABLE_I && pready_reg && PWRITE_I && wr_ok;

  always_comb
  begin
    rd_data = '0;
    mapped  = 1'b1;
    wr_ok   = 1'b0;
    if (is_jump)
    begin
      rd_data[FREQ_W-1:0] = jump_reg[jump_idx];
      wr_ok = (view_reg == FREQ_ZERO) && (in_range(wval, FREQ_ZERO, FREQ_400HZ) || wval == JUMP_OFF);
    end
    else
    begin
      case (PADDR_I)
        OFF_MAX:
        begin
          rd_data[FREQ_W-1:0] = max_reg;
          wr_ok = (view_reg == FREQ_ZERO) && in_range(wval, FREQ_ZERO, FREQ_120HZ);
        end
        OFF_MIN:
        begin
          rd_data[FREQ_W-1:0] = min_reg;
          wr_ok = (view_reg == FREQ_ZERO) && in_range(wval, FREQ_ZERO, FREQ_120HZ);
        end
        OFF_HSMAX:
        begin
          rd_data[FREQ_W-1:0] = hsmax_reg;
          wr_ok = (view_reg == FREQ_ZERO) && in_range(wval, FREQ_120HZ, FREQ_400HZ);
        end
        OFF_START:
        begin
          rd_data[FREQ_W-1:0] = start_reg;
          wr_ok = in_range(wval, FREQ_ZERO, FREQ_400HZ);
        end
        OFF_JOG:
        begin
          rd_data[FREQ_W-1:0] = jog_reg;
          wr_ok = in_range(wval, FREQ_ZERO, FREQ_400HZ);
        end
        OFF_VIEW:
        begin
          rd_data[FREQ_W-1:0] = view_reg;
          wr_ok = 1'b1;
        end
        OFF_ACCEL:
        begin
          rd_data[FREQ_W-1:0] = accel_reg;
          wr_ok = in_range(wval, ACCEL_MIN, FREQ_400HZ);
        end
        OFF_STATUS:
        begin
          rd_data[FREQ_W-1:0]  = run_reg;
          rd_data[ST_RUN_BIT]   = running_reg;
          rd_data[ST_SPEED_BIT] = at_speed_reg;
          rd_data[ST_JOG_BIT]   = jog_sync_reg;
        end
        default:
          mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end
    else
    begin
      pready_reg  <= access_start;
      if (access_start)
      begin
        pslverr_reg <= !mapped || (PWRITE_I && !wr_ok);
        prdata_reg  <= PWRITE_I ? '0 : rd_data;
      end
      else
      begin
        pslverr_reg <= 1'b0;
        prdata_reg  <= '0;
      end
    end
  end

  // limit registers; max and high-speed max mirror each other
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      max_reg   <= MAX_RST;
      min_reg   <= MIN_RST;
      hsmax_reg <= HSMAX_RST;
    end
    else if (wr_accept)
    begin
      if (PADDR_I == OFF_MAX || PADDR_I == OFF_HSMAX)
      begin
        max_reg   <= wval;
        hsmax_reg <= wval;
      end
      if (PADDR_I == OFF_MIN)
        min_reg <= wval;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      start_reg <= START_RST;
      jog_reg   <= JOG_RST;
      accel_reg <= ACCEL_RST;
      view_reg  <= VIEW_RST;
    end
    else if (wr_accept)
    begin
      if (PADDR_I == OFF_START)
        start_reg <= wval;
      if (PADDR_I == OFF_JOG)
        jog_reg <= wval;
      if (PADDR_I == OFF_ACCEL)
        accel_reg <= wval;
      if (PADDR_I == OFF_VIEW)
        view_reg <= wval;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      for (int i = 0; i < JUMP_N; i++)
        jump_reg[i] <= JUMP_OFF;
    end
    else if (wr_accept && is_jump)
      jump_reg[jump_idx] <= wval;
  end

  ofl_limit_calc u_limit_calc (
    .cmd_i      (CMD_FREQ_I),
    .run_i      (start_sync_reg),
    .jog_i      (jog_sync_reg),
    .jog_freq_i (jog_reg),
    .min_i      (min_reg),
    .max_i      (max_reg),
    .jump_i     (jump_reg),
    .target_o   (target_next)
  );

  // limited frequency registered every cycle
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      target_reg <= FREQ_ZERO;
    else
      target_reg <= target_next;
  end

  // ramp tick divider
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == 32'(RAMP_TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  // linear ramp toward the target, crossing bands on the way
  always_comb
  begin
    run_next = run_reg;
    case (ramp_state_reg)
      RAMP_IDLE:
        if (target_reg != FREQ_ZERO && target_reg >= start_reg)
          run_next = start_reg;
      RAMP_ACCEL:
        if (target_reg - run_reg > accel_reg)
          run_next = run_reg + accel_reg;
        else
          run_next = target_reg;
      RAMP_DECEL:
      begin
        if (run_reg - target_reg > accel_reg)
          run_next = run_reg - accel_reg;
        else
          run_next = target_reg;
        if (target_reg < start_reg && run_next < start_reg)
          run_next = FREQ_ZERO;
      end
      RAMP_STEADY:
        run_next = run_reg;
      default:
        run_next = FREQ_ZERO;
    endcase
    if (run_next == FREQ_ZERO && (target_reg == FREQ_ZERO || target_reg < start_reg))
      ramp_state_next = RAMP_IDLE;
    else if (run_next < target_reg)
      ramp_state_next = RAMP_ACCEL;
    else if (run_next > target_reg)
      ramp_state_next = RAMP_DECEL;
    else
      ramp_state_next = RAMP_STEADY;
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      run_reg        <= FREQ_ZERO;
      ramp_state_reg <= RAMP_IDLE;
      running_reg    <= 1'b0;
      at_speed_reg   <= 1'b0;
    end
    else if (tick_reg)
    begin
      run_reg        <= run_next;
      ramp_state_reg <= ramp_state_next;
      running_reg    <= (ramp_state_next != RAMP_IDLE);
      at_speed_reg   <= (ramp_state_next == RAMP_STEADY);
    end
  end

  assign PRDATA_O       = prdata_reg;
  assign PREADY_O       = pready_reg;
  assign PSLVERR_O      = pslverr_reg;
  assign OUT_FREQ_O     = run_reg;
  assign OUT_RUNNING_O  = running_reg;
  assign OUT_AT_SPEED_O = at_speed_reg;

  a_max_clamp: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    ##1 target_reg <= $past(max_reg))
    else $error("limited frequency above maximum");

  a_min_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    $past(start_sync_reg && !jog_sync_reg && min_reg <= max_reg) |-> target_reg >= $past(min_reg))
    else $error("running frequency below minimum");

  a_jog_bypass: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    $past(jog_sync_reg && jog_reg <= min_reg && jog_reg <= max_reg) |-> target_reg == $past(jog_reg))
    else $error("jog frequency not passed through");

  a_band_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    $past(start_sync_reg && !jog_sync_reg && band_hit(CMD_FREQ_I, jump_reg[0], jump_reg[1])
          && in_range(jump_reg[0], min_reg, max_reg)) |-> target_reg == $past(jump_reg[0]))
    else $error("band command not held at a bound");

  a_max_mirror: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    wr_accept && (PADDR_I == OFF_MAX || PADDR_I == OFF_HSMAX) |=> max_reg == hsmax_reg && max_reg == $past(wval))
    else $error("maximum settings not mirrored");

  a_view_lock: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    PSEL_I && PENABLE_I && pready_reg && PWRITE_I && view_reg != FREQ_ZERO && PADDR_I == OFF_MIN
      |=> $stable(min_reg) && $stable(max_reg))
    else $error("setting written while view select nonzero");

  a_max_range: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    PSEL_I && PENABLE_I && pready_reg && PWRITE_I && PADDR_I == OFF_MAX && wval > FREQ_120HZ
      |-> PSLVERR_O ##1 $stable(max_reg) && $stable(hsmax_reg))
    else $error("out of range maximum accepted");

  a_ramp_up: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    tick_reg && ramp_state_reg == RAMP_ACCEL && run_reg < target_reg
      |=> run_reg > $past(run_reg) && run_reg - $past(run_reg) <= $past(accel_reg))
    else $error("acceleration step wrong");

  a_pready_wait: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    access_start |=> PREADY_O ##1 !PREADY_O)
    else $error("apb answer not one wait state");

endmodule : ofl_limiter
`default_nettype wire

// >>> core/ofl_pkg.sv
// constants, register map and helpers of the output frequency limiter
package ofl_pkg;

  // frequencies are carried in units of 0.1 Hz
  localparam int           FREQ_W        = 16;
  typedef logic [FREQ_W-1:0] ofl_freq_t;

  localparam int           ADDR_W        = 8;
  localparam int           DATA_W        = 32;
  localparam int           JUMP_N        = 6;
  localparam int           BAND_N        = 3;

  // register byte offsets
  localparam logic [7:0]   OFF_MAX       = 8'h00;
  localparam logic [7:0]   OFF_MIN       = 8'h04;
  localparam logic [7:0]   OFF_HSMAX     = 8'h08;
  localparam logic [7:0]   OFF_START     = 8'h0c;
  localparam logic [7:0]   OFF_JOG       = 8'h10;
  localparam logic [7:0]   OFF_JUMP_BASE = 8'h14;
  localparam logic [7:0]   OFF_JUMP_LAST = 8'h28;
  localparam logic [7:0]   OFF_VIEW      = 8'h2c;
  localparam logic [7:0]   OFF_ACCEL     = 8'h30;
  localparam logic [7:0]   OFF_STATUS    = 8'h34;

  // setting limits and reset values
  localparam ofl_freq_t    FREQ_ZERO     = 16'h0000;
  localparam ofl_freq_t    FREQ_120HZ    = 16'h04b0;
  localparam ofl_freq_t    FREQ_400HZ    = 16'h0fa0;
  localparam ofl_freq_t    JUMP_OFF      = 16'h270f;
  localparam ofl_freq_t    MAX_RST       = FREQ_120HZ;
  localparam ofl_freq_t    MIN_RST       = FREQ_ZERO;
  localparam ofl_freq_t    HSMAX_RST     = FREQ_120HZ;
  localparam ofl_freq_t    START_RST     = 16'h0005;
  localparam ofl_freq_t    JOG_RST       = 16'h0032;
  localparam ofl_freq_t    ACCEL_RST     = 16'h0001;
  localparam ofl_freq_t    ACCEL_MIN     = 16'h0001;
  localparam ofl_freq_t    VIEW_RST      = 16'h0000;

  // status word fields
  localparam int           ST_RUN_BIT    = 16;
  localparam int           ST_SPEED_BIT  = 17;
  localparam int           ST_JOG_BIT    = 18;

  // ramp tick period
  localparam int           CLK_MHZ       = 200;
  localparam int           RAMP_TICK_US  = 1000;
  localparam int           RAMP_TICK_CYC = RAMP_TICK_US * CLK_MHZ;

  typedef enum logic [1:0] {RAMP_IDLE, RAMP_ACCEL, RAMP_DECEL, RAMP_STEADY} ofl_ramp_t;

  function automatic logic in_range(input ofl_freq_t v, input ofl_freq_t lo, input ofl_freq_t hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range

  // a band is live only when neither bound holds the disable code
  function automatic logic band_hit(input ofl_freq_t f, input ofl_freq_t a, input ofl_freq_t b);
    logic on;
    on = (a != JUMP_OFF) && (b != JUMP_OFF);
    if (a < b)
      return on && in_range(f, a, b);
    return on && in_range(f, b, a);
  endfunction : band_hit

endpackage : ofl_pkg

// >>> verif/ofl_cmd_partner.sv
// command source and output generator model around the limiter
`timescale 1ns/10ps
`default_nettype none
module ofl_cmd_partner
  import ofl_pkg::*;
(
  input  wire logic               clk_i,
  input  wire ofl_pkg::ofl_freq_t out_freq_i,
  output ofl_pkg::ofl_freq_t      cmd_o,
  output logic                    start_o,
  output logic                    jog_o
);
  int   win_lo = 0;
  int   win_hi = -1;
  int   hits   = 0;
  int   base   = 0;
  logic in_win;

  // window hits since the last watch call
  assign in_win = (hits > base);

  // command source changes just after an edge
  task automatic drive(input ofl_freq_t cmd, input logic start, input logic jog);
    @(posedge clk_i);
    cmd_o   <= cmd;
    start_o <= start;
    jog_o   <= jog;
  endtask : drive

  // generator side: note any running frequency inside a window
  task automatic watch(input int lo, input int hi);
    win_lo = lo;
    win_hi = hi;
    base   = hits;
  endtask : watch

  always @(posedge clk_i)
    if (int'(out_freq_i) >= win_lo && int'(out_freq_i) <= win_hi)
      hits <= hits + 1;
endmodule : ofl_cmd_partner
`default_nettype wire

// >>> verif/output_frequency_limiter_tb_top.sv
// self-checking bench of the output frequency limiter
`timescale 1ns/10ps
`default_nettype none
module output_frequency_limiter_tb_top;
  import ofl_pkg::*;
  localparam int TICK = 4;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = '0;
  logic [31:0] pwdata   = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ofl_freq_t   cmd;
  ofl_freq_t   out_freq;
  logic        start;
  logic        jog;
  logic        running;
  logic        at_speed;
  int          errors   = 0;
  int          compares = 0;
  int          sh [0:13] = '{1200, 0, 1200, 5, 50, 9999, 9999, 9999, 9999, 9999, 9999, 0, 1, 0};
  int          tc [0:5]  = '{450, 850, 100, 3500, 0, 600};
  int          ri [0:6]  = '{0, 1, 2, 2, 5, 5, 15};
  int          rv [0:6]  = '{1201, 1201, 1199, 4001, 4001, 9999, 1};

  always #2.5 clk = ~clk;

  ofl_limiter #(.RAMP_TICK_CYCLES(TICK)) i_dut (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CMD_FREQ_I(cmd), .START_I(start), .JOG_I(jog), .OUT_FREQ_O(out_freq),
    .OUT_RUNNING_O(running), .OUT_AT_SPEED_O(at_speed));

  ofl_cmd_partner i_src (
    .clk_i(clk), .out_freq_i(out_freq), .cmd_o(cmd), .start_o(start), .jog_o(jog));

  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input int idx, input int d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= 8'(idx * 4);
    pwdata  <= 32'(d);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t: no bus answer", $time);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // shadow register file decides the answer of each write
  task automatic reg_wr(input int idx, input int d);
    logic [31:0] rd;
    logic        err;
    logic        ok;
    case (idx)
      0, 1:                ok = d <= 1200;
      2:                   ok = d >= 1200 && d <= 4000;
      3, 4:                ok = d <= 4000;
      5, 6, 7, 8, 9, 10:   ok = d <= 4000 || d == 9999;
      11:                  ok = 1'b1;
      12:                  ok = d >= 1 && d <= 4000;
      default:             ok = 1'b0;
    endcase
    if (sh[11] != 0 && idx <= 10 && idx != 3 && idx != 4)
      ok = 1'b0;
    apb(1'b1, idx, d, rd, err);
    chk(32'(err), 32'(!ok), "write error flag");
    if (ok && idx < 13)
      sh[idx] = d;
    if (ok && (idx == 0 || idx == 2))
    begin
      sh[0] = d;
      sh[2] = d;
    end
  endtask : reg_wr

  task automatic reg_rd(input int idx);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 0, rd, err);
    chk(rd, (idx < 13) ? 32'(sh[idx]) : 32'h0, "read data");
    chk(32'(err), 32'(idx > 13), "read error flag");
  endtask : reg_rd

  // expected limited frequency from the shadow settings
  function automatic int lim(input logic s, input logic j, input int c);
    int f;
    int a;
    int b;
    if (j)
      return (sh[4] < sh[0]) ? sh[4] : sh[0];
    if (!s)
      return 0;
    f = c;
    for (int k = 2; k >= 0; k--)
    begin
      a = sh[5 + 2 * k];
      b = sh[6 + 2 * k];
      if (a != 9999 && b != 9999 && c >= ((a < b) ? a : b) && c <= ((a < b) ? b : a))
        f = a;
    end
    if (f < sh[1])
      f = sh[1];
    if (f > sh[0])
      f = sh[0];
    return f;
  endfunction : lim

  task automatic settle(input int e);
    int n;
    n = 0;
    while (!(out_freq === 16'(e) && at_speed === (e != 0)) && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(out_freq), 32'(e), "output frequency");
    chk(32'(at_speed), 32'(e != 0), "at speed");
    chk(32'(running), 32'(e != 0), "running");
    if (n >= 400)
    begin
      errors++;
      $display("wrong value at %0t: output never settled", $time);
      report_and_stop();
    end
  endtask : settle

  initial
  begin
    int          c;
    logic [31:0] rd;
    logic        err;
    void'($urandom(28));
    i_src.drive(16'h0000, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i <= 12; i++)
      reg_rd(i);
    reg_rd(15);
    $display("test reset values done");
    for (int i = 0; i < 7; i++)
      reg_wr(ri[i], rv[i]);
    reg_wr(2, 2000);
    reg_rd(0);
    reg_wr(0, 1000);
    reg_rd(2);
    $display("test ranges and copy done");
    reg_wr(11, 1);
    reg_wr(1, 500);
    reg_wr(6, 300);
    reg_wr(3, 5);
    reg_rd(1);
    reg_wr(11, 0);
    $display("test write lock done");
    reg_wr(2, 2000);
    reg_wr(1, 200);
    reg_wr(4, 150);
    reg_wr(5, 300);
    reg_wr(6, 600);
    reg_wr(7, 900);
    reg_wr(8, 800);
    reg_wr(12, 4000);
    for (int i = 0; i < 6; i++)
    begin
      i_src.drive(16'(tc[i]), 1'b1, 1'b0);
      settle(lim(1'b1, 1'b0, tc[i]));
    end
    i_src.drive(16'(3000), 1'b0, 1'b1);
    settle(lim(1'b0, 1'b1, 3000));
    $display("test directed limits done");
    repeat (12)
    begin
      c = 10 + int'($urandom % 3000);
      i_src.drive(16'(c), 1'b1, 1'b0);
      settle(lim(1'b1, 1'b0, c));
    end
    $display("test random commands done");
    i_src.drive(16'(0), 1'b0, 1'b0);
    settle(0);
    reg_wr(12, 50);
    i_src.watch(300, 600);
    i_src.drive(16'(1000), 1'b1, 1'b0);
    settle(lim(1'b1, 1'b0, 1000));
    chk(32'(i_src.in_win), 32'h1, "ramp through band");
    apb(1'b0, 13, 0, rd, err);
    chk(rd, (32'h1 << ST_RUN_BIT) | (32'h1 << ST_SPEED_BIT) | 32'(lim(1'b1, 1'b0, 1000)), "status word");
    chk(32'(err), 32'h0, "status error flag");
    $display("test ramp through band done");
    report_and_stop();
  end
endmodule : output_frequency_limiter_tb_top
`default_nettype wire
